// [src/feo_pkg.sv]
// constants and carrier types for the flash erase-select and ram overlay block
package feo_pkg;

  // widths
  localparam int unsigned REG_ADDR_W = 4;
  localparam int unsigned REG_DATA_W = 16;
  localparam int unsigned CPU_ADDR_W = 24;
  localparam int unsigned LOWER_W    = 8;
  localparam int unsigned UPPER_W    = 8;
  localparam int unsigned BLOCKS     = 12;

  // register offsets on the plain register port
  localparam logic [3:0] OFF_UPPER      = 4'h0;
  localparam logic [3:0] OFF_OVERLAY    = 4'h1;
  localparam logic [3:0] OFF_WRITE_CTRL = 4'h2;

  // upper erase-select register
  localparam logic [7:0] UPPER_RESET = 8'h00;
  localparam logic [7:0] UPPER_MASK  = 8'h0F;

  // overlay control register
  localparam logic [15:0] OVERLAY_RESET = 16'h0000;
  localparam logic [15:0] OVERLAY_MASK  = 16'h000F;
  localparam int unsigned OVL_SEL_BIT   = 3;

  // write-control register fields
  localparam int unsigned SWE_BIT = 0;
  localparam int unsigned PIN_BIT = 1;
  localparam logic        SWE_RESET = 1'b0;

  // flash map: eight 4 kB blocks, one 32 kB block, three 64 kB blocks
  localparam logic [23:0] SMALL_END = 24'h00_8000;
  localparam logic [23:0] MID_END   = 24'h01_0000;
  localparam logic [23:0] LARGE_END = 24'h04_0000;
  localparam logic [3:0]  BLOCK_MID  = 4'h8;
  localparam logic [3:0]  BLOCK_NONE = 4'hF;

  // register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } feo_bus_type;

  // cpu access presented for routing
  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
  } feo_cpu_type;

  // routing decision for a cpu access
  typedef struct packed {
    logic        flash_select;
    logic        ram_select;
    logic [11:0] ram_addr;
    logic [3:0]  block;
  } feo_route_type;

endpackage : feo_pkg

// [src/feo_flash_ctrl.sv]
// upper erase-block select, software write enable and ram overlay control
`timescale 1ns/1ps

//Contract
// - upper select clears on reset, standby modes and write pin low
// - upper select bits held zero while software write enable is clear
// - only blocks whose select bit is one may be erased
// - more than one select bit set clears both select registers
// - flash disabled: upper select reads zero, writes ignored
// - upper select is 8 bits, bits 0-3 blocks 8-11, bits 4-7 zero
// - blocks 0-7 4 kB from zero, block 8 32 kB, 9-11 64 kB
// - overlay register clears on power-on reset and hardware standby
// - overlay register keeps its value across software standby
// - overlay bits 4 to 15 always read zero
// - overlay select one protects every block from program and erase
// - overlay select zero: no emulation, no protection, area don't care
// - area code 0 picks block 0, code 1 picks block 1
// - area codes 2 to 7 pick blocks 2 to 7
// - software write enable can be set only while write pin high
// - write pin low blocks all programming and erasing
module feo_flash_ctrl (
  // clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_rstn,
  // register port
  input  wire feo_pkg::feo_bus_type  i_bus,
  output logic [15:0]                o_rdata,
  // device state
  input  wire logic                  i_hw_standby,
  input  wire logic                  i_sw_standby,
  input  wire logic                  i_flash_enabled,
  input  wire logic                  i_flash_write_pin,
  // adjacent erase-select logic
  input  wire logic [7:0]            i_erase_select_lower,
  output logic                       o_lower_clear,
  // protection and erase enables
  output logic [7:0]                 o_erase_select_upper,
  output logic                       o_soft_write_enable,
  output logic                       o_program_erase_allowed,
  output logic [11:0]                o_erase_enable,
  // cpu access routing
  input  wire feo_pkg::feo_cpu_type  i_cpu,
  output feo_pkg::feo_route_type     o_route
);

  // number of ones in the combined select bits
  function automatic logic [3:0] count_ones(input logic [11:0] bits);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 12; k++) begin
      n = n + {3'b000, bits[k]};
    end
    return n;
  endfunction : count_ones

  // erase block that holds a cpu address
  function automatic logic [3:0] block_of(input logic [23:0] addr);
    logic [3:0] blk;
    if (addr < feo_pkg::SMALL_END) begin
      blk = {1'b0, addr[14:12]};
    end else if (addr < feo_pkg::MID_END) begin
      blk = feo_pkg::BLOCK_MID;
    end else if (addr < feo_pkg::LARGE_END) begin
      blk = feo_pkg::BLOCK_MID + {2'b00, addr[17:16]};
    end else begin
      blk = feo_pkg::BLOCK_NONE;
    end
    return blk;
  endfunction : block_of

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  // state
  logic [7:0]             upper;
  logic [15:0]            overlay;
  logic                   swe;
  logic [7:0]             next_upper;
  logic [15:0]            next_overlay;
  logic                   next_swe;
  logic                   next_lower_clear;
  logic [11:0]            next_erase_enable;
  logic                   next_pe_allowed;
  logic [15:0]            next_rdata;
  feo_pkg::feo_route_type next_route;

  // address decode
  wire logic hit_upper   = (i_bus.addr == feo_pkg::OFF_UPPER);
  wire logic hit_overlay = (i_bus.addr == feo_pkg::OFF_OVERLAY);
  wire logic hit_ctrl    = (i_bus.addr == feo_pkg::OFF_WRITE_CTRL);
  wire logic wr_upper    = i_bus.wr && hit_upper && i_flash_enabled;
  wire logic wr_overlay  = i_bus.wr && hit_overlay;
  wire logic wr_ctrl     = i_bus.wr && hit_ctrl;

  // software write enable: set only with the pin high, dropped when it falls
  wire logic swe_clear = i_hw_standby || !i_flash_write_pin;
  assign next_swe = swe_clear ? 1'b0
                  : wr_ctrl   ? (i_bus.wdata[feo_pkg::SWE_BIT] && i_flash_write_pin)
                  : swe;

  a_swe_needs_pin: assert property ($rose(swe) |-> $past(i_flash_write_pin))
    else $error("write enable rose without write pin high");

  // write enable follows the pin, hardware standby and control writes
  a_swe_pin_drop: assert property (!i_flash_write_pin |=> !swe)
    else $error("write enable kept with write pin low");
  a_swe_hw_drop: assert property (i_hw_standby |=> !swe)
    else $error("write enable kept in hardware standby");
  a_swe_write_set: assert property (
      (wr_ctrl && i_bus.wdata[feo_pkg::SWE_BIT] && i_flash_write_pin && !i_hw_standby)
      |=> swe)
    else $error("write enable not set by control write");
  a_swe_write_clear: assert property (
      (wr_ctrl && !i_bus.wdata[feo_pkg::SWE_BIT]) |=> !swe)
    else $error("write enable not cleared by control write");

  // upper select: write, forced clears, single-bit limit
  wire logic [7:0] upper_written = wr_upper ? (i_bus.wdata[7:0] & feo_pkg::UPPER_MASK)
                                            : upper;
  wire logic upper_forced_zero = i_hw_standby || i_sw_standby
                              || !i_flash_write_pin || !swe;
  wire logic multi_bit = (count_ones({upper_written[3:0], i_erase_select_lower}) > 4'h1);
  assign next_upper = (upper_forced_zero || multi_bit) ? feo_pkg::UPPER_RESET
                                                       : upper_written;
  assign next_lower_clear = multi_bit;

  a_pin_low_clears: assert property (!i_flash_write_pin |=> upper == 8'h00)
    else $error("upper select not cleared with write pin low");
  a_standby_clears: assert property ((i_sw_standby || i_hw_standby) |=> upper == 8'h00)
    else $error("upper select not cleared in standby");
  a_swe_low_zero: assert property (!swe |=> upper[3:0] == 4'h0)
    else $error("upper select bits set without write enable");
  a_single_bit: assert property (multi_bit |=> (upper == 8'h00) && o_lower_clear)
    else $error("multiple select bits not cleared");
  a_upper_reserved: assert property (upper[7:4] == 4'h0)
    else $error("upper select reserved bits nonzero");
  a_disabled_write: assert property (
      (i_bus.wr && hit_upper && !i_flash_enabled && !upper_forced_zero && !multi_bit)
      |=> $stable(upper))
    else $error("write to upper select taken while flash disabled");

  // upper select write path, hold and lower clear request
  a_upper_write_lands: assert property (
      (wr_upper && !upper_forced_zero && !multi_bit)
      |=> ({8'h00, upper} == ($past(i_bus.wdata) & {8'h00, feo_pkg::UPPER_MASK})))
    else $error("upper select write not stored");
  a_upper_idle_hold: assert property (
      (!wr_upper && !upper_forced_zero && !multi_bit) |=> $stable(upper))
    else $error("upper select changed without a write");
  a_lower_clear_only: assert property (!multi_bit |=> !o_lower_clear)
    else $error("lower clear raised without multiple select bits");
  a_upper_one_hot: assert property ($onehot0(upper[3:0]))
    else $error("more than one upper select bit set");
  a_upper_read_reserved: assert property (
      (i_bus.rd && hit_upper) |=> o_rdata[15:4] == 12'h000)
    else $error("upper select read shows reserved bits");

  // overlay control: cleared only by reset or hardware standby
  assign next_overlay = i_hw_standby ? feo_pkg::OVERLAY_RESET
                      : wr_overlay   ? (i_bus.wdata & feo_pkg::OVERLAY_MASK)
                      : overlay;

  a_overlay_hw_clear: assert property (i_hw_standby |=> overlay == 16'h0000)
    else $error("overlay not cleared in hardware standby");
  a_overlay_sw_keep: assert property (
      (i_sw_standby && !i_hw_standby && !wr_overlay) |=> $stable(overlay))
    else $error("overlay changed across software standby");
  a_overlay_reserved: assert property (overlay[15:4] == 12'h000)
    else $error("overlay reserved bits nonzero");

  // overlay write path and read-back
  a_overlay_write_lands: assert property (
      (wr_overlay && !i_hw_standby)
      |=> (overlay == ($past(i_bus.wdata) & feo_pkg::OVERLAY_MASK)))
    else $error("overlay write not stored with reserved bits cleared");
  a_overlay_hw_wins: assert property (
      (i_hw_standby && wr_overlay) |=> overlay == feo_pkg::OVERLAY_RESET)
    else $error("overlay write beat hardware standby");
  a_overlay_read_reserved: assert property (
      (i_bus.rd && hit_overlay) |=> o_rdata[15:4] == 12'h000)
    else $error("overlay read shows reserved bits");

  // software standby: upper cleared while the overlay carries on
  sequence s_sw_standby;
    i_sw_standby && !i_hw_standby && !wr_overlay;
  endsequence
  property p_sw_standby;
    s_sw_standby |=> (upper == feo_pkg::UPPER_RESET) && $stable(overlay);
  endproperty
  a_sw_standby_split: assert property (p_sw_standby)
    else $error("software standby did not clear upper and keep overlay");

  // program/erase protection and per-block erase enables
  wire logic emulating = overlay[feo_pkg::OVL_SEL_BIT];
  wire logic [11:0] sel_bits = {upper[3:0], i_erase_select_lower};  // bit k = block k
  assign next_pe_allowed = i_flash_write_pin && swe && !emulating;
  assign next_erase_enable = next_pe_allowed ? sel_bits
                                             : 12'h000;

  a_erase_selected: assert property (
      $past(next_pe_allowed) |-> o_erase_enable == $past(sel_bits))
    else $error("erase enables differ from select bits");
  a_overlay_protects: assert property (
      emulating |=> !o_program_erase_allowed && (o_erase_enable == 12'h000))
    else $error("flash not protected while overlay selected");
  a_pin_low_protects: assert property (!i_flash_write_pin |=> !o_program_erase_allowed)
    else $error("program/erase allowed with write pin low");

  // protection lifted only when pin, write enable and overlay all allow it
  a_protect_lifted: assert property (
      (i_flash_write_pin && swe && !emulating) |=> o_program_erase_allowed)
    else $error("program/erase blocked with overlay off and writes enabled");
  a_swe_low_protects: assert property (!swe |=> !o_program_erase_allowed)
    else $error("program/erase allowed without write enable");
  a_pin_erase_off: assert property (
      !i_flash_write_pin |=> o_erase_enable == 12'h000)
    else $error("erase enabled with write pin low");
  a_blocked_no_erase: assert property (!next_pe_allowed |=> o_erase_enable == 12'h000)
    else $error("erase enabled while program/erase blocked");

  // write pin low: registers and erase enables clear on the same edge; the check looks at erase enables a cycle later
  sequence s_pin_low;
    !i_flash_write_pin;
  endsequence
  sequence s_cleared;
    (upper == feo_pkg::UPPER_RESET) && !swe;
  endsequence
  property p_pin_low_chain;
    s_pin_low |=> s_cleared ##1 (o_erase_enable == 12'h000);
  endproperty
  a_pin_low_chain: assert property (p_pin_low_chain)
    else $error("write pin low did not clear and protect in turn");

  // cpu routing: chosen 4 kB block goes to overlay ram while emulating
  wire logic [3:0] cpu_block = block_of(i_cpu.addr);
  wire logic [3:0] area_block = {1'b0, overlay[2:0]};
  wire logic overlay_hit = i_cpu.valid && emulating && (cpu_block == area_block);
  always_comb begin
    next_route.block        = cpu_block;
    next_route.ram_select   = overlay_hit;
    next_route.ram_addr     = i_cpu.addr[11:0];
    next_route.flash_select = i_cpu.valid && !overlay_hit
                           && (cpu_block != feo_pkg::BLOCK_NONE);
  end

  a_block_eight: assert property (
      (i_cpu.valid && i_cpu.addr >= 24'h00_8000 && i_cpu.addr < 24'h01_0000)
      |=> o_route.block == 4'h8)
    else $error("32 kB region not mapped to block 8");
  a_block_eleven: assert property (
      (i_cpu.valid && i_cpu.addr >= 24'h03_0000 && i_cpu.addr < 24'h04_0000)
      |=> o_route.block == 4'hB)
    else $error("top 64 kB region not mapped to block 11");
  a_emulation_off: assert property (!emulating |=> !o_route.ram_select)
    else $error("ram selected with emulation off");

  // remaining map boundaries and overlay area decode
  a_block_nine: assert property (
      (i_cpu.valid && i_cpu.addr >= 24'h01_0000 && i_cpu.addr < 24'h02_0000)
      |=> o_route.block == 4'h9)
    else $error("first 64 kB region not mapped to block 9");
  a_block_ten: assert property (
      (i_cpu.valid && i_cpu.addr >= 24'h02_0000 && i_cpu.addr < 24'h03_0000)
      |=> o_route.block == 4'hA)
    else $error("second 64 kB region not mapped to block 10");
  a_block_none: assert property (
      (i_cpu.valid && i_cpu.addr >= 24'h04_0000)
      |=> !o_route.flash_select && !o_route.ram_select)
    else $error("address beyond the flash map selected a memory");
  a_area_zero: assert property (
      (i_cpu.valid && emulating && overlay[2:0] == 3'h0 && i_cpu.addr < 24'h00_1000)
      |=> o_route.ram_select)
    else $error("area code 0 did not overlay block 0");
  a_area_seven: assert property (
      (i_cpu.valid && emulating && overlay[2:0] == 3'h7
       && i_cpu.addr >= 24'h00_7000 && i_cpu.addr < 24'h00_8000)
      |=> o_route.ram_select)
    else $error("area code 7 did not overlay block 7");
  a_area_miss: assert property (
      (i_cpu.valid && cpu_block != area_block) |=> !o_route.ram_select)
    else $error("access outside the chosen block sent to ram");
  a_ram_or_flash: assert property (!(o_route.ram_select && o_route.flash_select))
    else $error("access routed to ram and flash at once");
  a_flash_when_off: assert property (
      (i_cpu.valid && !emulating && cpu_block != feo_pkg::BLOCK_NONE)
      |=> o_route.flash_select)
    else $error("flash not selected with emulation off");

  // overlay write, one to five spare cycles, then an access into the chosen block
  sequence s_overlay_on;
    wr_overlay && i_bus.wdata[3] && !i_hw_standby;
  endsequence
  sequence s_access_area;
    i_cpu.valid && emulating && (cpu_block == area_block);
  endsequence
  property p_redirect;
    s_overlay_on ##[2:6] s_access_area |=> o_route.ram_select && !o_route.flash_select;
  endproperty
  a_redirect_area: assert property (p_redirect)
    else $error("access to chosen block not redirected to ram");

  // read data, one cycle after the read strobe
  wire logic [15:0] rd_upper = i_flash_enabled ? {8'h00, upper} : 16'h0000;
  wire logic [15:0] rd_ctrl  = {14'h0000, i_flash_write_pin, swe};
  assign next_rdata = !i_bus.rd   ? 16'h0000
                    : hit_upper   ? rd_upper
                    : hit_overlay ? overlay
                    : hit_ctrl    ? rd_ctrl
                    : 16'h0000;

  a_disabled_read: assert property (
      (i_bus.rd && hit_upper && !i_flash_enabled) |=> o_rdata == 16'h0000)
    else $error("upper select readable while flash disabled");

  // register state
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      upper   <= feo_pkg::UPPER_RESET;
      overlay <= feo_pkg::OVERLAY_RESET;
      swe     <= feo_pkg::SWE_RESET;
    end else begin
      upper   <= next_upper;
      overlay <= next_overlay;
      swe     <= next_swe;
    end
  end

  // registered outputs
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata                 <= 16'h0000;
      o_lower_clear           <= 1'b0;
      o_erase_select_upper    <= feo_pkg::UPPER_RESET;
      o_soft_write_enable     <= feo_pkg::SWE_RESET;
      o_program_erase_allowed <= 1'b0;
      o_erase_enable          <= 12'h000;
      o_route                 <= '0;
    end else begin
      o_rdata                 <= next_rdata;
      o_lower_clear           <= next_lower_clear;
      o_erase_select_upper    <= next_upper;
      o_soft_write_enable     <= next_swe;
      o_program_erase_allowed <= next_pe_allowed;
      o_erase_enable          <= next_erase_enable;
      o_route                 <= next_route;
    end
  end

endmodule : feo_flash_ctrl

// [test/feo_flash_ctrl_tb.sv]
// self-checking bench for the erase-select and ram overlay control block
`timescale 1ns/1ps
module feo_flash_ctrl_tb;
  logic                   i_clock;
  logic                   i_rstn;
  feo_pkg::feo_bus_type   bus;
  logic [15:0]            rdata;
  logic                   hw_sb;
  logic                   sw_sb;
  logic                   fl_en;
  logic                   pin;
  logic [7:0]             lower;
  logic                   lower_clr;
  logic [7:0]             upper;
  logic                   swe;
  logic                   pe_ok;
  logic [11:0]            erase_en;
  feo_pkg::feo_cpu_type   cpu;
  feo_pkg::feo_route_type route;
  int                     n_mismatch;
  int                     cmp_count;
  int                     k;

  feo_flash_ctrl dut_u (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_bus(bus), .o_rdata(rdata),
    .i_hw_standby(hw_sb), .i_sw_standby(sw_sb), .i_flash_enabled(fl_en),
    .i_flash_write_pin(pin), .i_erase_select_lower(lower), .o_lower_clear(lower_clr),
    .o_erase_select_upper(upper), .o_soft_write_enable(swe),
    .o_program_erase_allowed(pe_ok), .o_erase_enable(erase_en), .i_cpu(cpu), .o_route(route)
  );

  // free-running clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge i_clock);
    bus.wr    <= 1'b0;
  endtask : wr

  // one-cycle read, data looked at in the following cycle only
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clock);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge i_clock);
    bus.rd   <= 1'b0;
    #1;
    chk({2'b00, rdata}, {2'b00, e});
  endtask : rd

  // one cpu access, routing answer one cycle later
  task automatic rt(input logic [23:0] a, input logic [17:0] e);
    @(posedge i_clock);
    cpu <= {1'b1, a};
    @(posedge i_clock);
    cpu.valid <= 1'b0;
    #1;
    chk(route, e);
  endtask : rt

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : cyc

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    $display("watchdog expired");
    close_out();
  end

  // main sequence
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    bus = '0;
    cpu = '0;
    hw_sb = 1'b0;
    sw_sb = 1'b0;
    fl_en = 1'b1;
    pin = 1'b1;
    lower = 8'h00;
    i_rstn = 1'b0;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(feo_pkg::OFF_UPPER, 16'h0000);
    rd(feo_pkg::OFF_OVERLAY, 16'h0000);
    rd(4'h5, 16'h0000);
    wr(feo_pkg::OFF_WRITE_CTRL, 16'h0001);
    rd(feo_pkg::OFF_WRITE_CTRL, 16'h0003);
    // each upper bit selects one of blocks 8 to 11, upper nibble read-only
    for (k = 0; k < 4; k++) begin
      wr(feo_pkg::OFF_UPPER, 16'hFFF0 | (16'h0001 << k));
      rd(feo_pkg::OFF_UPPER, 16'h0001 << k);
      chk({6'h00, erase_en}, 18'h0_0100 << k);
    end
    // more than one select bit across both registers
    wr(feo_pkg::OFF_UPPER, 16'h0003);
    rd(feo_pkg::OFF_UPPER, 16'h0000);
    @(posedge i_clock);
    lower <= 8'h01;
    wr(feo_pkg::OFF_UPPER, 16'h0001);
    rd(feo_pkg::OFF_UPPER, 16'h0000);
    @(posedge i_clock);
    lower <= 8'h03;
    cyc(2);
    chk({17'h0_0000, lower_clr}, 18'h0_0001);
    @(posedge i_clock);
    lower <= 8'h04;
    cyc(2);
    chk({6'h00, erase_en}, 18'h0_0004);
    // overlay on: every area code, reserved bits written as ones
    for (k = 0; k < 8; k++) begin
      wr(feo_pkg::OFF_OVERLAY, 16'hFFF8 | k[15:0]);
      rd(feo_pkg::OFF_OVERLAY, 16'h0008 | k[15:0]);
      rt(24'h00_0010 | (k[23:0] << 12), {2'b01, 12'h010, k[3:0]});
      chk({17'h0_0000, pe_ok}, 18'h0_0000);
      chk({6'h00, erase_en}, 18'h0_0000);
    end
    // overlay off: area bits ignored, protection lifted
    wr(feo_pkg::OFF_OVERLAY, 16'h0005);
    rt(24'h00_5010, {2'b10, 12'h010, 4'h5});
    chk({17'h0_0000, pe_ok}, 18'h0_0001);
    chk({6'h00, erase_en}, 18'h0_0004);
    // block map boundaries
    rt(24'h00_7FFF, {2'b10, 12'hFFF, 4'h7});
    rt(24'h00_8000, {2'b10, 12'h000, 4'h8});
    rt(24'h01_0000, {2'b10, 12'h000, 4'h9});
    rt(24'h02_0ABC, {2'b10, 12'hABC, 4'hA});
    rt(24'h03_FFFF, {2'b10, 12'hFFF, 4'hB});
    rt(24'h04_0000, {2'b00, 12'h000, 4'hF});
    // software standby clears upper only
    @(posedge i_clock);
    lower <= 8'h00;
    wr(feo_pkg::OFF_UPPER, 16'h0002);
    rd(feo_pkg::OFF_UPPER, 16'h0002);
    @(posedge i_clock);
    sw_sb <= 1'b1;
    @(posedge i_clock);
    sw_sb <= 1'b0;
    rd(feo_pkg::OFF_UPPER, 16'h0000);
    rd(feo_pkg::OFF_OVERLAY, 16'h0005);
    // flash disabled: reads zero, writes dropped
    wr(feo_pkg::OFF_UPPER, 16'h0001);
    @(posedge i_clock);
    fl_en <= 1'b0;
    rd(feo_pkg::OFF_UPPER, 16'h0000);
    wr(feo_pkg::OFF_UPPER, 16'h0004);
    @(posedge i_clock);
    fl_en <= 1'b1;
    rd(feo_pkg::OFF_UPPER, 16'h0001);
    // software write enable clear forces upper to zero
    wr(feo_pkg::OFF_WRITE_CTRL, 16'h0000);
    rd(feo_pkg::OFF_UPPER, 16'h0000);
    wr(feo_pkg::OFF_UPPER, 16'h0001);
    rd(feo_pkg::OFF_UPPER, 16'h0000);
    // write pin low: hardware protection
    wr(feo_pkg::OFF_WRITE_CTRL, 16'h0001);
    wr(feo_pkg::OFF_UPPER, 16'h0001);
    @(posedge i_clock);
    pin <= 1'b0;
    cyc(2);
    chk({10'h000, upper}, 18'h0_0000);
    chk({16'h0000, swe, pe_ok}, 18'h0_0000);
    wr(feo_pkg::OFF_WRITE_CTRL, 16'h0001);
    rd(feo_pkg::OFF_WRITE_CTRL, 16'h0000);
    @(posedge i_clock);
    pin <= 1'b1;
    // hardware standby clears the overlay register
    @(posedge i_clock);
    hw_sb <= 1'b1;
    @(posedge i_clock);
    hw_sb <= 1'b0;
    rd(feo_pkg::OFF_OVERLAY, 16'h0000);
    // power-on reset in mid-run clears the overlay and the write enable
    wr(feo_pkg::OFF_OVERLAY, 16'h000C);
    rd(feo_pkg::OFF_OVERLAY, 16'h000C);
    @(posedge i_clock);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(feo_pkg::OFF_OVERLAY, 16'h0000);
    rd(feo_pkg::OFF_WRITE_CTRL, 16'h0002);
    close_out();
  end
endmodule : feo_flash_ctrl_tb
